// ### common/pdw_pkg.sv
// Purpose: shared constants and types for the parallel dac write port host
// Assumes: 20 MHz reference clock, apb register access with 32-bit data
// Notes: pin timing figures are plain defaults, shorten or widen as needed
package pdw_pkg;
    // clock and pin timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_SETUP_NS = 50;
    localparam int T_STROBE_NS = 100;
    localparam int T_HOLD_NS = 50;
    localparam int T_UPDATE_NS = 100;
    localparam int CNT_W = 4;
    // least times, rounded up to whole cycles, counted down to zero
    localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
    localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
    localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
    localparam logic [CNT_W-1:0] UPDATE_CNT = CNT_W'((T_UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    // register offsets
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_CMD = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_STAT = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_UPD = 12'h00C;
    // control register fields
    localparam int CTRL_W = 4;
    localparam int CTRL_SLEEP = 0;
    localparam int CTRL_ZERO = 1;
    localparam int CTRL_HOLD = 2;
    localparam int CTRL_AUTO = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    // command register fields
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_UPPER_LSB = 2;
    localparam int CMD_DATA_MSB = 9;
    localparam int CMD_CHAN_LSB = 10;
    localparam int CMD_CHAN_MSB = 12;
    localparam int CMD_MODE = 13;
    localparam int CMD_SYS = 14;
    // status and update register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_REFUSED = 1;
    localparam int UPD_GO = 0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic [2:0] CHAN_NONE = 3'h0;

    // pins toward the dac
    typedef struct packed {
        logic cs_n;
        logic store_n;
        logic mode;
        logic [2:0] channel_select;
        logic [7:0] data_bits_upper;
        logic data_bit_1;
        logic data_bit_0;
        logic output_update_n;
        logic async_zero_n;
        logic sleep_request_n;
    } pdw_pins_t;

    localparam pdw_pins_t PINS_RST = '{cs_n: 1'b1, store_n: 1'b1, mode: 1'b0, channel_select: 3'h0,
        data_bits_upper: 8'h00, data_bit_1: 1'b0, data_bit_0: 1'b0, output_update_n: 1'b1,
        async_zero_n: 1'b1, sleep_request_n: 1'b1};

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_PULSE} pdw_state_t;

    // whole state of the controller
    typedef struct packed {
        pdw_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CTRL_W-1:0] ctrl;
        logic refused;
        pdw_pins_t pins;
    } pdw_regs_t;
endpackage : pdw_pkg

// ### rtl/pdw_host.sv
// Purpose: host side driver of a parallel dac write port, ordered over apb
// Assumes: one 20 MHz clock, dac pins are outputs only, device keeps its own rules
// Notes: writes to command or update while a cycle runs are dropped and flagged
// Summary of operation
// - update low at store rise updates automatically
// - host strobes store with select and address
// - device accepts writes only with select low
// - upper eight lines carry eight msbs
// - two lowest lines carry the two lsbs
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module pdw_host
    import pdw_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // dac pins
    output pdw_pins_t pins_o
);

    // address match, used by reads and writes
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic rst_sync1;
    logic rst_n;
    pdw_regs_t r;
    pdw_regs_t next_r;
    logic acc;
    logic wr_acc;
    logic mapped;
    logic busy;

    // reset release through two flops
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n <= rst_sync1;
        end
    end

    // apb decode, zero wait states
    assign acc = psel_i & penable_i;
    assign wr_acc = acc & pwrite_i;
    assign busy = (r.st != ST_IDLE);
    assign mapped = hit(paddr_i, OFS_CTRL) | hit(paddr_i, OFS_CMD) | hit(paddr_i, OFS_STAT) | hit(paddr_i, OFS_UPD);
    assign pready_o = acc;
    assign pslverr_o = acc & ~mapped;
    assign pins_o = r.pins;

    // read mux, unmapped and write-only words read zero
    always_comb begin
        prdata_o = RDATA_ZERO;
        if (hit(paddr_i, OFS_CTRL)) begin
            prdata_o[CTRL_W-1:0] = r.ctrl;
        end else if (hit(paddr_i, OFS_STAT)) begin
            prdata_o[STAT_BUSY] = busy;
            prdata_o[STAT_REFUSED] = r.refused;
        end
    end

    // next state: registers, pin levels and write sequencer
    always_comb begin
        next_r = r;
        if (wr_acc && hit(paddr_i, OFS_CTRL)) begin
            next_r.ctrl = pwdata_i[CTRL_W-1:0];
        end
        // level pins follow control bits
        next_r.pins.sleep_request_n = ~next_r.ctrl[CTRL_SLEEP];
        next_r.pins.async_zero_n = ~next_r.ctrl[CTRL_ZERO];
        // software clears refused, a new refusal below wins
        if (wr_acc && hit(paddr_i, OFS_STAT) && pwdata_i[STAT_REFUSED]) begin
            next_r.refused = 1'b0;
        end
        unique case (r.st)
            ST_IDLE: begin
                next_r.pins.output_update_n = ~next_r.ctrl[CTRL_HOLD];
                if (wr_acc && hit(paddr_i, OFS_CMD)) begin
                    next_r.pins.cs_n = 1'b0;
                    next_r.pins.mode = pwdata_i[CMD_MODE];
                    next_r.pins.channel_select = pwdata_i[CMD_CHAN_MSB:CMD_CHAN_LSB];
                    if (!pwdata_i[CMD_MODE] && pwdata_i[CMD_SYS]) begin
                        next_r.pins.channel_select = CHAN_NONE;
                    end
                    next_r.pins.data_bits_upper = pwdata_i[CMD_DATA_MSB:CMD_UPPER_LSB];
                    next_r.pins.data_bit_1 = pwdata_i[CMD_DATA_LSB + 1];
                    next_r.pins.data_bit_0 = pwdata_i[CMD_DATA_LSB];
                    // auto update holds update low across the store rising edge
                    next_r.pins.output_update_n = ~(next_r.ctrl[CTRL_HOLD] | next_r.ctrl[CTRL_AUTO]);
                    next_r.cnt = SETUP_CNT;
                    next_r.st = ST_SETUP;
                end else if (wr_acc && hit(paddr_i, OFS_UPD) && pwdata_i[UPD_GO]) begin
                    next_r.pins.output_update_n = 1'b0;
                    next_r.cnt = UPDATE_CNT;
                    next_r.st = ST_PULSE;
                end
            end
            ST_SETUP: begin
                if (r.cnt == CNT_ZERO) begin
                    next_r.pins.store_n = 1'b0;
                    next_r.cnt = STROBE_CNT;
                    next_r.st = ST_STROBE;
                end else begin
                    next_r.cnt = r.cnt - CNT_ONE;
                end
            end
            ST_STROBE: begin
                if (r.cnt == CNT_ZERO) begin
                    next_r.pins.store_n = 1'b1;
                    next_r.cnt = HOLD_CNT;
                    next_r.st = ST_HOLD;
                end else begin
                    next_r.cnt = r.cnt - CNT_ONE;
                end
            end
            ST_HOLD: begin
                if (r.cnt == CNT_ZERO) begin
                    next_r.pins.cs_n = 1'b1;
                    next_r.pins.output_update_n = ~next_r.ctrl[CTRL_HOLD];
                    next_r.st = ST_IDLE;
                end else begin
                    next_r.cnt = r.cnt - CNT_ONE;
                end
            end
            ST_PULSE: begin
                if (r.cnt == CNT_ZERO) begin
                    next_r.pins.output_update_n = ~next_r.ctrl[CTRL_HOLD];
                    next_r.st = ST_IDLE;
                end else begin
                    next_r.cnt = r.cnt - CNT_ONE;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
        // orders that arrive while a cycle runs are dropped
        if (busy && wr_acc && (hit(paddr_i, OFS_CMD) || hit(paddr_i, OFS_UPD))) begin
            next_r.refused = 1'b1;
        end
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{st: ST_IDLE, cnt: CNT_ZERO, ctrl: CTRL_RST, refused: 1'b0, pins: PINS_RST};
        end else begin
            r <= next_r;
        end
    end

    // checks on the pin sequence
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    logic cmd_take;
    logic upd_take;
    assign cmd_take = !busy && wr_acc && hit(paddr_i, OFS_CMD);
    assign upd_take = !busy && wr_acc && hit(paddr_i, OFS_UPD) && pwdata_i[UPD_GO];

    a_store_needs_select: assert property (!r.pins.store_n |-> !r.pins.cs_n)
        else $error("store strobe low without chip select");
    a_store_rise_select: assert property ($rose(r.pins.store_n) |-> !r.pins.cs_n)
        else $error("store strobe rose without chip select");
    a_strobe_width_two: assert property ($fell(r.pins.store_n) |=> !r.pins.store_n ##1 r.pins.store_n)
        else $error("store strobe width wrong");
    a_cmd_to_strobe: assert property (cmd_take |=> r.pins.store_n ##1 !r.pins.store_n)
        else $error("store strobe not issued after command");
    a_auto_update_edge: assert property ($rose(r.pins.store_n) && r.ctrl[CTRL_AUTO] |-> !r.pins.output_update_n)
        else $error("update not low at store rise in auto mode");
    a_system_chan_zero: assert property (cmd_take && !pwdata_i[CMD_MODE] && pwdata_i[CMD_SYS]
        |=> r.pins.channel_select == CHAN_NONE)
        else $error("system control write kept a channel address");
    a_mode_and_chan: assert property (cmd_take |=> r.pins.mode == $past(pwdata_i[CMD_MODE])
        && (r.pins.channel_select == $past(pwdata_i[CMD_CHAN_MSB:CMD_CHAN_LSB]) || !r.pins.mode))
        else $error("mode or channel not taken from command");
    a_data_lines_map: assert property (cmd_take |=> r.pins.data_bits_upper == $past(pwdata_i[CMD_DATA_MSB:CMD_UPPER_LSB])
        && r.pins.data_bit_1 == $past(pwdata_i[CMD_DATA_LSB + 1])
        && r.pins.data_bit_0 == $past(pwdata_i[CMD_DATA_LSB]))
        else $error("data lines do not match command word");
    a_update_pulse_two: assert property (upd_take |=> !r.pins.output_update_n [*2] ##1
        (r.pins.output_update_n || r.ctrl[CTRL_HOLD]))
        else $error("update pulse wrong length");
    a_zero_follows_ctrl: assert property (r.pins.async_zero_n == !r.ctrl[CTRL_ZERO]
        && r.pins.sleep_request_n == !r.ctrl[CTRL_SLEEP])
        else $error("clear or sleep pin disagrees with control");
    a_data_stable_busy: assert property (!r.pins.cs_n && !$rose(r.pins.cs_n) && $past(!r.pins.cs_n)
        |-> $stable(r.pins.data_bits_upper))
        else $error("data lines moved during a write");

endmodule : pdw_host

// ### testbench/pdw_dac_model.sv
// Purpose: behavioural model of the parallel dac that the host drives
// Assumes: pins come straight from the host flops, no byte loading
// Notes: the clear level is the midscale bias code, a plain default
`timescale 1ns/1ps
module pdw_dac_model
    import pdw_pkg::*;
#(
    parameter logic [9:0] CLEAR_CODE = 10'h200
) (
    // pins from the host
    input wire pdw_pins_t pins_i
);
    logic [9:0] data_q [8];
    logic [9:0] dac_q [8];
    logic [9:0] ctrl_q [8];
    logic [7:0] sub_q [8];
    logic [9:0] word;
    logic asleep;
    // word assembly from the upper lines and the two low lines
    assign word = {pins_i.data_bits_upper, pins_i.data_bit_1, pins_i.data_bit_0};
    assign asleep = !pins_i.sleep_request_n;
    // start with everything at zero
    initial begin
        for (int i = 0; i < 8; i++) begin
            data_q[i] = 10'h000;
            dac_q[i] = 10'h000;
            ctrl_q[i] = 10'h000;
            sub_q[i] = 8'h00;
        end
    end
    // capture on the store rising edge, only while selected
    always @(posedge pins_i.store_n) begin
        if (!pins_i.cs_n) begin
            if (pins_i.mode) begin
                data_q[pins_i.channel_select] = word;
            end else begin
                ctrl_q[pins_i.channel_select] = word;
            end
            if (!pins_i.output_update_n) begin
                for (int i = 0; i < 8; i++) dac_q[i] = data_q[i];
            end
        end
    end
    // update low copies every data register at once
    always @(negedge pins_i.output_update_n) begin
        for (int i = 0; i < 8; i++) dac_q[i] = data_q[i];
    end
    // clear drives main dacs back to the bias point and offset dacs to zero
    always @(negedge pins_i.async_zero_n) begin
        for (int i = 0; i < 8; i++) begin
            dac_q[i] = CLEAR_CODE;
            sub_q[i] = 8'h00;
        end
    end
endmodule : pdw_dac_model

// ### testbench/testbench.sv
// Purpose: self-checking bench for the parallel dac host over apb
// Assumes: zero wait apb slave, one 20 MHz clock
// Notes: the pin cycle end is found by polling the busy bit
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
    import pdw_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pdw_pins_t pins;
    int n_fail = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic er;
    // clock source
    always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
    pdw_host dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pins_o(pins));
    pdw_dac_model model (.pins_i(pins));
    // one apb transfer, then one idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        @(posedge ref_clk_i);
        while (pready !== 1'b1) @(posedge ref_clk_i);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk_i);
    endtask : apb
    // poll busy until the pin cycle has ended
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_STAT, 32'h0);
            n++;
        end while (rd[STAT_BUSY] !== 1'b0 && n < 20);
        // a pin cycle that never ends counts as a mismatch
        if (rd[STAT_BUSY] !== 1'b0) n_fail++;
    endtask : wait_idle
    function automatic logic [31:0] cmd(logic sys, logic mode, logic [2:0] ch, logic [9:0] d);
        return {17'h0, sys, mode, ch, d};
    endfunction : cmd
    // verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    // watchdog
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        end_sim();
    end
    // test sequence
    initial begin
        repeat (16) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        apb(1'b1, OFS_CMD, cmd(1'b0, 1'b1, 3'h5, 10'h2A5));
        wait_idle();
        `CHK({model.data_q[5], model.dac_q[5]}, {10'h2A5, 10'h000})
        apb(1'b1, OFS_UPD, 32'h1);
        wait_idle();
        `CHK(model.dac_q[5], 10'h2A5)
        // auto then hold: the write itself moves the dac register
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFS_CTRL, i ? 32'h4 : 32'h8);
            apb(1'b1, OFS_CMD, cmd(1'b0, 1'b1, 3'(2 + i), 10'h155 + 10'(i)));
            wait_idle();
            `CHK(model.dac_q[2 + i], 10'h155 + 10'(i))
        end
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CMD, cmd(1'b0, 1'b0, 3'h3, 10'h0C3));
        wait_idle();
        `CHK({model.ctrl_q[3], model.data_q[3]}, {10'h0C3, 10'h156})
        apb(1'b1, OFS_CMD, cmd(1'b1, 1'b0, 3'h6, 10'h03C));
        wait_idle();
        `CHK({model.ctrl_q[0], model.ctrl_q[6]}, {10'h03C, 10'h000})
        // second command lands while busy and must be dropped
        apb(1'b1, OFS_CMD, cmd(1'b0, 1'b1, 3'h1, 10'h3FF));
        apb(1'b1, OFS_CMD, cmd(1'b0, 1'b1, 3'h1, 10'h111));
        wait_idle();
        `CHK({rd[STAT_REFUSED], model.data_q[1]}, {1'b1, 10'h3FF})
        apb(1'b1, OFS_STAT, 32'h2);
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK(rd[STAT_REFUSED], 1'b0)
        apb(1'b1, OFS_CTRL, 32'h3);
        repeat (2) @(posedge ref_clk_i);
        `CHK({model.asleep, model.dac_q[5], model.sub_q[5]}, {1'b1, 10'h200, 8'h00})
        end_sim();
    end
endmodule : testbench
